// ===== src/block_transfer_swap_sequencer.v
// Purpose: sequencing of load_multiple, store_multiple and atomic_swap
// Assumes: memory answers in the cycle of the request; mem_abort is same-clock logic
// Notes: registers and the core register bank sit behind AHB-Lite
//
// Behaviour
// - write-back at end of second cycle; store drives first register then
// - store of base_reg: original value if first, updated value otherwise
// - load of base_reg in list replaces the written-back base
// - abort may come on any word of a block transfer; handled recoverably
// - store abort: finish, then trap; only base write-back changes state
// - load abort: no register updates from aborting word on; pc kept
// - load abort: base_reg restored to written-back value if write-back asked
// - trap only after the aborted load has completed
// - cycles: load nS+1N+1I, load with pc (n+1)S+2N+1I, store (n-1)S+2N
// - stack aliases: full pre-adjusts on store; ascending store goes up
// - write-back only on request; user flag restores status or user bank
// - swap read then write indivisible, no interrupt between them
// - swap reads base address, writes source_reg, old value to destination
// - lock high across both swap read and write cycles
// - swap byte flag 1 stores source bits 7:0; 0 is word swap
// - abort on swap read, write or both takes the trap
// - swap takes 1S+2N+1I
// - list bit i selects register i, ascending order and address
// - addresses come from base_reg, pre bit and up bit
`timescale 1ns/1ps
`default_nettype none
`include "seq_regs.vh"
module block_transfer_swap_sequencer #(
  parameter NREG = 16,
  parameter CNTW = 8
) (
  input wire clock,
  input wire rst_b,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire mem_req,
  output wire mem_write,
  output wire mem_byte,
  output wire mem_lock,
  output wire [1:0] mem_cycle,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_abort,
  output reg data_abort_trap,
  output reg status_restore,
  output wire user_bank_xfer
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_ADDR = 4'h1;
  localparam S_XFER = 4'h2;
  localparam S_INT = 4'h3;
  localparam S_REF_N = 4'h4;
  localparam S_REF_S = 4'h5;
  localparam S_SW_S = 4'h6;
  localparam S_SW_RD = 4'h7;
  localparam S_SW_WR = 4'h8;
  localparam S_SW_INT = 4'h9;
  reg [3:0] state_q;
  reg [31:0] ctrl_q;
  reg [15:0] list_q;
  reg [15:0] rem_q;
  reg [3:0] regsel_q;
  reg [31:0] rf [0:NREG-1];
  reg [31:0] wb_val_q;
  reg [31:0] orig_base_q;
  reg [31:0] swap_q;
  reg first_q;
  reg abort_q;
  reg done_q;
  reg aborted_q;
  reg [CNTW-1:0] s_cnt_q;
  reg [CNTW-1:0] n_cnt_q;
  reg [CNTW-1:0] i_cnt_q;
  reg dph_q;
  reg dph_wr_q;
  reg [3:0] dph_idx_q;
  // ----------------------------------------
  // decoded instruction fields
  // ----------------------------------------
  wire is_load = ctrl_q[`CTRL_LOAD];
  wire is_swap = ctrl_q[`CTRL_SWAP];
  wire stack = ctrl_q[`CTRL_STACK];
  wire pre_eff = stack ? (ctrl_q[`CTRL_FULL] ^ is_load) : ctrl_q[`CTRL_PRE];
  wire up_eff = stack ? (ctrl_q[`CTRL_ASC] ^ is_load) : ctrl_q[`CTRL_UP];
  wire wb_en = ctrl_q[`CTRL_WB];
  wire user_f = ctrl_q[`CTRL_USER];
  wire [3:0] base_idx = ctrl_q[`CTRL_BASE_HI:`CTRL_BASE_LO];
  wire [3:0] src_idx = ctrl_q[`CTRL_SRC_HI:`CTRL_SRC_LO];
  wire [3:0] dst_idx = ctrl_q[`CTRL_DST_HI:`CTRL_DST_LO];
  wire [31:0] base_val = rf[base_idx];
  wire [4:0] list_cnt;
  wire [3:0] cur_idx;
  wire [4:0] rem_cnt;
  wire [31:0] start_addr;
  wire [31:0] final_base;
  list_scan #(.WIDTH(16), .IDXW(4), .CNTW(5)) u_scan_list (
    .list(list_q),
    .low_idx(),
    .count(list_cnt)
  );
  list_scan #(.WIDTH(16), .IDXW(4), .CNTW(5)) u_scan_rem (
    .list(rem_q),
    .low_idx(cur_idx),
    .count(rem_cnt)
  );
  xfer_addr #(.CNTW(5)) u_addr (
    .base(base_val),
    .count(list_cnt),
    .pre(pre_eff),
    .up(up_eff),
    .start(start_addr),
    .final_base(final_base)
  );

  // ----------------------------------------
  // memory side
  // ----------------------------------------
  wire in_xfer = (state_q == S_XFER);
  assign mem_req = in_xfer | (state_q == S_SW_RD) | (state_q == S_SW_WR);
  assign mem_write = (in_xfer & ~is_load) | (state_q == S_SW_WR);
  assign mem_byte = is_swap & ctrl_q[`CTRL_BYTE] & mem_req;
  assign mem_lock = (state_q == S_SW_RD) | (state_q == S_SW_WR);
  assign user_bank_xfer = ~is_swap & user_f & (state_q != S_IDLE) &
    ~(is_load & list_q[15]);
  assign mem_cycle = (state_q == S_ADDR) ? `CYC_N :
    (in_xfer & ~is_load & first_q) ? `CYC_N :
    in_xfer ? `CYC_S :
    (state_q == S_REF_N) | (state_q == S_SW_RD) | (state_q == S_SW_WR) ? `CYC_N :
    (state_q == S_REF_S) | (state_q == S_SW_S) ? `CYC_S :
    (state_q == S_INT) | (state_q == S_SW_INT) ? `CYC_I : `CYC_NONE;
  wire ab_now = mem_req & mem_abort;
  wire ab_any = abort_q | ab_now;
  wire last_word = (rem_cnt == 5'd1);
  wire [1:0] lane = mem_addr[1:0];
  wire [31:0] rd_byte = {24'h000000, mem_rdata[{lane, 3'b000} +: 8]};
  always @* begin
    if (is_swap) begin
      mem_wdata = ctrl_q[`CTRL_BYTE] ? {4{rf[src_idx][7:0]}} : rf[src_idx];
    end else if (in_xfer & ~is_load) begin
      mem_wdata = rf[cur_idx];
    end else begin
      mem_wdata = 32'h0000_0000;
    end
  end
  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign hreadyout = ce;
  assign hresp = 1'b0;
  wire aph = hsel & htrans[1] & hready;
  wire [3:0] aidx = haddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
  wire bus_wr = dph_q & dph_wr_q;
  wire idle = (state_q == S_IDLE);
  wire go = bus_wr & (dph_idx_q == `OFS_CTRL) & hwdata[`CTRL_GO] & idle;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dph_q <= 1'b0;
      dph_wr_q <= 1'b0;
      dph_idx_q <= 4'h0;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      dph_q <= aph;
      dph_wr_q <= aph & hwrite;
      dph_idx_q <= aidx;
      hrdata <= 32'h0000_0000;
      if (aph & ~hwrite) begin
        case (aidx)
          `OFS_CTRL: hrdata <= ctrl_q;
          `OFS_LIST: hrdata <= {16'h0000, list_q};
          `OFS_STATUS: hrdata <= {29'h0, aborted_q, done_q, ~idle};
          `OFS_REGSEL: hrdata <= {28'h0, regsel_q};
          `OFS_REGDATA: hrdata <= rf[regsel_q];
          `OFS_COUNTS: hrdata <= {{(32-3*CNTW){1'b0}}, i_cnt_q, n_cnt_q, s_cnt_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ----------------------------------------
  // control registers and sequencer
  // ----------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      ctrl_q <= `CTRL_RESET;
      list_q <= `LIST_RESET;
      rem_q <= `LIST_RESET;
      regsel_q <= 4'h0;
      wb_val_q <= 32'h0000_0000;
      orig_base_q <= 32'h0000_0000;
      swap_q <= 32'h0000_0000;
      mem_addr <= 32'h0000_0000;
      first_q <= 1'b0;
      abort_q <= 1'b0;
      done_q <= 1'b0;
      aborted_q <= 1'b0;
      s_cnt_q <= {CNTW{1'b0}};
      n_cnt_q <= {CNTW{1'b0}};
      i_cnt_q <= {CNTW{1'b0}};
      data_abort_trap <= 1'b0;
      status_restore <= 1'b0;
    end else if (ce) begin
      data_abort_trap <= 1'b0;
      status_restore <= 1'b0;
      if (bus_wr & idle) begin
        case (dph_idx_q)
          `OFS_CTRL: ctrl_q <= {hwdata[31:1], 1'b0};
          `OFS_LIST: list_q <= hwdata[15:0];
          `OFS_REGSEL: regsel_q <= hwdata[3:0];
          default: regsel_q <= regsel_q;
        endcase
      end
      // per-instruction cycle tally
      case (mem_cycle)
        `CYC_S: s_cnt_q <= s_cnt_q + {{(CNTW-1){1'b0}}, 1'b1};
        `CYC_N: n_cnt_q <= n_cnt_q + {{(CNTW-1){1'b0}}, 1'b1};
        `CYC_I: i_cnt_q <= i_cnt_q + {{(CNTW-1){1'b0}}, 1'b1};
        default: s_cnt_q <= s_cnt_q;
      endcase
      if (ab_now) begin
        abort_q <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (go) begin
            done_q <= 1'b0;
            abort_q <= 1'b0;
            s_cnt_q <= {CNTW{1'b0}};
            n_cnt_q <= {CNTW{1'b0}};
            i_cnt_q <= {CNTW{1'b0}};
            state_q <= hwdata[`CTRL_SWAP] ? S_SW_S : S_ADDR;
          end
        end
        S_ADDR: begin
          rem_q <= list_q;
          mem_addr <= start_addr;
          wb_val_q <= final_base;
          orig_base_q <= base_val;
          first_q <= 1'b1;
          state_q <= S_XFER;
        end
        S_XFER: begin
          first_q <= 1'b0;
          rem_q[cur_idx] <= 1'b0;
          mem_addr <= mem_addr + `WORD_STEP;
          if (last_word) begin
            if (is_load) begin
              state_q <= S_INT;
            end else begin
              data_abort_trap <= ab_any;
              aborted_q <= ab_any;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
          if (is_load & ~ab_any & (cur_idx == `PC_IDX) & user_f) begin
            status_restore <= 1'b1;
          end
        end
        S_INT: begin
          if (list_q[15] & ~abort_q) begin
            state_q <= S_REF_N;
          end else begin
            data_abort_trap <= abort_q;
            aborted_q <= abort_q;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_REF_N: state_q <= S_REF_S;
        S_REF_S: begin
          aborted_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        S_SW_S: begin
          mem_addr <= base_val;
          state_q <= S_SW_RD;
        end
        S_SW_RD: begin
          swap_q <= ctrl_q[`CTRL_BYTE] ? rd_byte : mem_rdata;
          state_q <= S_SW_WR;
        end
        S_SW_WR: state_q <= S_SW_INT;
        S_SW_INT: begin
          data_abort_trap <= abort_q;
          aborted_q <= abort_q;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // register bank; later writes take priority
  // ----------------------------------------
  always @(posedge clock) begin
    if (ce) begin
      if (bus_wr & idle & (dph_idx_q == `OFS_REGDATA)) begin
        rf[regsel_q] <= hwdata;
      end
      if (in_xfer & first_q & wb_en) begin
        rf[base_idx] <= wb_val_q;
      end
      if (in_xfer & is_load & ~ab_any) begin
        rf[cur_idx] <= mem_rdata;
      end
      if ((state_q == S_INT) & abort_q) begin
        rf[base_idx] <= wb_en ? wb_val_q : orig_base_q;
      end
      if ((state_q == S_SW_INT) & ~abort_q) begin
        rf[dst_idx] <= swap_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/seq_regs.vh
// Purpose: register map, fields and cycle codes of the block transfer / swap sequencer
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes: included by bare name
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH

// ----------------------------------------
// register word indices, taken from haddr bits 5:2
// ----------------------------------------
`define OFS_CTRL 4'h0
`define OFS_LIST 4'h1
`define OFS_STATUS 4'h2
`define OFS_REGSEL 4'h3
`define OFS_REGDATA 4'h4
`define OFS_COUNTS 4'h5
`define ADDR_IDX_HI 5
`define ADDR_IDX_LO 2

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_GO 0
`define CTRL_SWAP 1
`define CTRL_LOAD 2
`define CTRL_PRE 3
`define CTRL_UP 4
`define CTRL_WB 5
`define CTRL_USER 6
`define CTRL_BYTE 7
`define CTRL_BASE_HI 11
`define CTRL_BASE_LO 8
`define CTRL_SRC_HI 15
`define CTRL_SRC_LO 12
`define CTRL_DST_HI 19
`define CTRL_DST_LO 16
`define CTRL_STACK 20
`define CTRL_FULL 21
`define CTRL_ASC 22
`define CTRL_RESET 32'h0000_0000
`define LIST_RESET 16'h0000

// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ABORTED 2

// ----------------------------------------
// cycle type codes on mem_cycle
// ----------------------------------------
`define CYC_NONE 2'h0
`define CYC_N 2'h1
`define CYC_S 2'h2
`define CYC_I 2'h3

`define PC_IDX 4'hf
`define WORD_STEP 32'h0000_0004

`endif

// ===== src/list_scan.v
// Purpose: lowest selected register and count of a transfer list
// Assumes: list bit i selects register i
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module list_scan #(
  parameter WIDTH = 16,
  parameter IDXW = 4,
  parameter CNTW = 5
) (
  input wire [WIDTH-1:0] list,
  output reg [IDXW-1:0] low_idx,
  output reg [CNTW-1:0] count
);
  integer i;
  always @* begin
    low_idx = {IDXW{1'b0}};
    count = {CNTW{1'b0}};
    for (i = WIDTH - 1; i >= 0; i = i - 1) begin
      if (list[i]) begin
        low_idx = i[IDXW-1:0];
        count = count + {{(CNTW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/xfer_addr.v
// Purpose: first transfer address and written-back base of a block transfer
// Assumes: words of four bytes, lowest register at lowest address
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
`include "seq_regs.vh"
module xfer_addr #(
  parameter CNTW = 5
) (
  input wire [31:0] base,
  input wire [CNTW-1:0] count,
  input wire pre,
  input wire up,
  output reg [31:0] start,
  output reg [31:0] final_base
);
  wire [31:0] span;
  assign span = {{(30-CNTW){1'b0}}, count, 2'b00};
  always @* begin
    if (up) begin
      final_base = base + span;
      start = pre ? base + `WORD_STEP : base;
    end else begin
      final_base = base - span;
      start = pre ? base - span : base - span + `WORD_STEP;
    end
  end
endmodule
`default_nettype wire

// ===== sim/seq_chk.sv
// Purpose: port checker of the sequencer
// Assumes: ce stays high while an instruction runs
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "seq_regs.vh"
module seq_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_byte,
  input wire logic mem_lock,
  input wire logic [1:0] mem_cycle,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_abort,
  input wire logic data_abort_trap,
  input wire logic status_restore
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic seen_q;
  // ------
  // abort seen since the last trap
  // ------
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
      seen_q <= 1'b0;
    else
      seen_q <= (seen_q | (mem_req & mem_abort)) & ~data_abort_trap;
  // ------
  // properties
  // ------
  lock_read_first_a: assert property (
    $rose(mem_lock) |-> mem_req && !mem_write)
    else $error("lock not opened by a read");
  lock_pair_a: assert property (
    mem_lock && !mem_write |=> mem_lock && mem_write && mem_req)
    else $error("lock dropped before write");
  swap_addr_a: assert property (
    mem_lock && !mem_write |=> mem_addr == $past(mem_addr))
    else $error("swap write moved");
  swap_end_a: assert property (
    mem_lock && mem_write |=> !mem_lock && mem_cycle == `CYC_I)
    else $error("swap not closed by internal cycle");
  swap_n_a: assert property (
    mem_lock |-> mem_req && mem_cycle == `CYC_N)
    else $error("locked access not n cycle");
  store_step_a: assert property (
    mem_req && mem_write && !mem_lock && mem_cycle == `CYC_S |->
      mem_addr == $past(mem_addr) + 32'h4)
    else $error("store word address step wrong");
  byte_rep_a: assert property (
    mem_byte && mem_write |-> mem_wdata == {4{mem_wdata[7:0]}})
    else $error("byte not on all lanes");
  byte_lock_a: assert property (mem_byte |-> mem_lock)
    else $error("byte access outside swap");
  trap_late_a: assert property (
    data_abort_trap |-> seen_q && !mem_req)
    else $error("trap without abort or mid transfer");
  abort_trap_a: assert property (
    mem_req && mem_abort |-> ##[1:40] data_abort_trap)
    else $error("abort never trapped");
  restore_clean_a: assert property (status_restore |-> !seen_q)
    else $error("status restored after abort");
  swap_c: cover property (mem_lock && mem_write);
  trap_c: cover property (data_abort_trap);
  restore_c: cover property (status_restore);
endmodule
bind block_transfer_swap_sequencer seq_chk i_chk (
  .clock, .rst_b, .mem_req, .mem_write, .mem_byte, .mem_lock, .mem_cycle, .mem_addr,
  .mem_wdata, .mem_abort, .data_abort_trap, .status_restore
);
`default_nettype wire

// ===== sim/mem_model.sv
// Purpose: memory and abort manager at the far side
// Assumes: answers in the request cycle, byte swaps word aligned
// Notes: abort_addr set by the bench
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clock,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_byte,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_abort
);
  logic [31:0] mem [64];
  logic [31:0] abort_addr = 32'hffff_ffff;
  logic [31:0] junk = 32'h5a5a_a5a5;
  wire [5:0] idx = mem_addr[7:2];
  // abort on any word of an instruction
  assign mem_abort = mem_req && mem_addr == abort_addr;
  // idle bus shows a moving pattern
  assign mem_rdata = (mem_req && !mem_write) ? mem[idx] : junk;
  // aborted writes dropped; never taken away while locked
  always @(posedge clock) begin
    junk <= {junk[30:0], ~junk[31]};
    if (mem_req && mem_write && !mem_abort && mem_byte)
      mem[idx][7:0] <= mem_wdata[7:0];
    else if (mem_req && mem_write && !mem_abort)
      mem[idx] <= mem_wdata;
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench of the sequencer
// Assumes: ce high while an instruction runs
// Notes: bank reached through regsel and regdata
`timescale 1ns/1ps
`default_nettype none
`include "seq_regs.vh"
module tb;
  localparam logic [31:0] a_ctl = {26'h0, `OFS_CTRL, 2'h0};
  localparam logic [31:0] a_list = {26'h0, `OFS_LIST, 2'h0};
  localparam logic [31:0] a_st = {26'h0, `OFS_STATUS, 2'h0};
  localparam logic [31:0] a_sel = {26'h0, `OFS_REGSEL, 2'h0};
  localparam logic [31:0] a_dat = {26'h0, `OFS_REGDATA, 2'h0};
  localparam logic [31:0] a_cnt = {26'h0, `OFS_COUNTS, 2'h0};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata, r, lo;
  logic hreadyout, hresp, mem_req, mem_write, mem_byte, mem_abort;
  logic [5:0] wi;
  logic data_abort_trap, status_restore, user_bank_xfer;
  logic ub_seen = 1'b0;
  int fail_count = 0;
  int n_checks = 0;
  int n_trap = 0;
  int n_rest = 0;
  int rl [3] = '{1, 5, 7};
  // row: control, start offset, expected counts
  logic [63:0] rows [12] = '{
    64'h00000030_00000202, 64'h00000038_04000202, 64'h00000020_f8000202,
    64'h00000028_f4000202, 64'h00000034_00010103, 64'h0000003c_04010103,
    64'h00000024_f8010103, 64'h0000002c_f4010103, 64'h00300020_f4000202,
    64'h00700024_f8010103, 64'h00100024_04010103, 64'h00500020_00000202};
  block_transfer_swap_sequencer i_dut (
    .clock, .rst_b, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_write, .mem_byte,
    .mem_lock(), .mem_cycle(), .mem_addr, .mem_wdata, .mem_rdata, .mem_abort,
    .data_abort_trap, .status_restore, .user_bank_xfer);
  mem_model i_mem (
    .clock, .mem_req, .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata, .mem_abort);
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    n_trap <= n_trap + int'(data_abort_trap === 1'b1);
    n_rest <= n_rest + int'(status_restore === 1'b1);
    ub_seen <= ub_seen | (user_bank_xfer === 1'b1);
  end
  // ------
  // tasks
  // ------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [31:0] a);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic setr(input logic [31:0] i, input logic [31:0] v);
    ahb(1'b1, a_sel, i);
    ahb(1'b1, a_dat, v);
  endtask
  task automatic getr(input logic [31:0] i);
    ahb(1'b1, a_sel, i);
    rd(a_dat);
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] l);
    ahb(1'b1, a_list, l);
    ahb(1'b1, a_ctl, c | 32'h1);
    for (int k = 0; k < 60 && r[1:0] !== 2'b10; k++)
      rd(a_st);
    chk("done", {30'h0, r[1:0]}, 32'h2);
    repeat (3) @(posedge clock);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish;
  end
  // ------
  // sequence
  // ------
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(a_ctl);
    chk("ctrl", r, `CTRL_RESET);
    rd(a_list);
    chk("list", r, {16'h0, `LIST_RESET});
    rd(a_st);
    chk("status", r, 32'h0);
    rd(32'h18);
    chk("unmapped", r, 32'h0);
    chk("resp", {31'h0, hresp}, 32'h0);
    ce <= 1'b0;
    @(negedge clock);
    chk("ready", {31'h0, hreadyout}, 32'h0);
    @(posedge clock);
    ce <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      lo = 32'h100 + {{24{rows[i][31]}}, rows[i][31:24]};
      setr(0, 32'h100);
      for (int k = 0; k < 3; k++) begin
        setr(rl[k], 32'ha000_0000 + i * 16 + k);
        wi = 6'(lo[7:2] + k);
        i_mem.mem[wi] = 32'hb000_0000 + i * 16 + k;
      end
      run(rows[i][63:32], 32'h00a2);
      rd(a_cnt);
      chk("counts", r, {8'h0, rows[i][23:0]});
      getr(0);
      chk("base", r, rows[i][31] ? 32'hf4 : 32'h10c);
      for (int k = 0; k < 3; k++) begin
        getr(rl[k]);
        if (rows[i][34])
          chk("load", r, 32'hb000_0000 + i * 16 + k);
        else begin
          wi = 6'(lo[7:2] + k);
          chk("store", i_mem.mem[wi], 32'ha000_0000 + i * 16 + k);
        end
      end
    end
    setr(1, 32'h100);
    run(32'h130, 32'h6);
    chk("base first", i_mem.mem[0], 32'h100);
    setr(2, 32'h100);
    run(32'h230, 32'h6);
    chk("base second", i_mem.mem[1], 32'h108);
    i_mem.mem[0] = 32'h1234_5678;
    setr(1, 32'h100);
    run(32'h134, 32'h6);
    getr(1);
    chk("load base", r, 32'h1234_5678);
    i_mem.abort_addr = 32'h104;
    i_mem.mem[1] = 32'hdead_0001;
    setr(0, 32'h100);
    run(32'h30, 32'h00a2);
    chk("aborted flag", {31'h0, r[`ST_ABORTED]}, 32'h1);
    chk("kept word", i_mem.mem[1], 32'hdead_0001);
    chk("store trap", n_trap, 1);
    getr(0);
    chk("store wb", r, 32'h10c);
    setr(1, 32'h100);
    setr(2, 32'h2222);
    setr(15, 32'h1500);
    run(32'h134, 32'h8006);
    getr(1);
    chk("restored base", r, 32'h10c);
    getr(2);
    chk("no load", r, 32'h2222);
    getr(15);
    chk("pc kept", r, 32'h1500);
    chk("load trap", n_trap, 2);
    i_mem.abort_addr = 32'hffff_ffff;
    setr(0, 32'h100);
    run(32'h54, 32'h8001);
    rd(a_cnt);
    chk("pc counts", r, 32'h010203);
    chk("restore", n_rest, 1);
    chk("no user bank", {31'h0, ub_seen}, 32'h0);
    run(32'h50, 32'h2);
    chk("user bank", {31'h0, ub_seen}, 32'h1);
    getr(0);
    chk("no wb", r, 32'h1234_5678);
    setr(2, 32'h40);
    setr(3, 32'h3333_3333);
    i_mem.mem[16] = 32'h4444_4444;
    run(32'h43202, 32'h0);
    rd(a_cnt);
    chk("swap counts", r, 32'h010201);
    chk("swap mem", i_mem.mem[16], 32'h3333_3333);
    getr(4);
    chk("swap dst", r, 32'h4444_4444);
    setr(2, 32'h44);
    setr(3, 32'hcafe_beef);
    i_mem.mem[17] = 32'h1122_3344;
    run(32'h33282, 32'h0);
    chk("byte mem", i_mem.mem[17], 32'h1122_33ef);
    getr(3);
    chk("byte dst", r, 32'h44);
    i_mem.abort_addr = 32'h44;
    run(32'h43202, 32'h0);
    chk("swap trap", n_trap, 3);
    // reset in the middle of an instruction
    ahb(1'b1, a_list, 32'h00a2);
    ahb(1'b1, a_ctl, 32'h31);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(a_st);
    chk("reset status", r, 32'h0);
    rd(a_ctl);
    chk("reset ctrl", r, `CTRL_RESET);
    tally_and_finish;
  end
endmodule
`default_nettype wire
